// [src/slpe_engine.sv]
`include "slpe_regs.svh"
// Functional notes
// RULE_01: first byte of each packet is total length including length and sum bytes.
// RULE_02: second byte is the eight-bit sum of payload bytes only.
// RULE_03: payload holds exactly length minus two bytes.
// RULE_04: answer every received packet with 0xCC if intact, else 0x33. Intact packets longer than 13 bytes also get 0x33.
// RULE_05: acknowledge reflects reception only, never command validity.
// RULE_06: host reads until first non-zero byte, taken as the answer.
// RULE_07: device may send zeros first; first non-zero byte is the length.
// RULE_08: after the length byte, sum and payload follow with no gaps.
// RULE_09: device skips zero bytes and takes first non-zero byte as host answer.
// RULE_10: after a negative answer the host resends the command.
// RULE_11: first payload byte is a command code, parameters follow.
// RULE_12: three-byte probe 0x20 sets status to success and acknowledges.
// RULE_13: three-byte query 0x23 returns one-byte packet with last status.
// RULE_14: setup 0x21 is eleven bytes: address then count, both MSB first.
// RULE_15: setup erases the whole region before the acknowledge is sent.
// RULE_16: write 0x24 programs payload at current address, then advances it.
// RULE_17: host sends at most eight data bytes per write packet.
// RULE_18: programming stops once setup byte count has been received.
// RULE_19: a negatively answered write leaves the address unchanged.
// RULE_20: host sends writes only after setup or another write.
// RULE_21: host follows setup and writes with a status query.
// RULE_22: seven-byte jump 0x22 takes MSB-first address, acknowledges, then jumps.
// RULE_23: three-byte restart 0x25 acknowledges first, then requests device reset.
// RULE_24: async link: two 0x55 sync bytes, answered with 0xCC once locked.
// RULE_25: sync link: host is clock master, idle high, second-edge capture.
// RULE_26: checksum truncated to eight bits; mismatch gives a negative answer.
// RULE_27: status codes: distinct values for success, unknown, bad address, failure.
module slpe_engine
  import slpe_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic link_is_async,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  output logic rx_ready,
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic clock_polarity_select,
  output logic clock_phase_select,
  output logic erase_req,
  output logic [31:0] erase_addr,
  output logic [31:0] erase_size,
  input wire logic erase_done,
  input wire logic erase_ok,
  input wire logic addr_ok,
  output logic prog_req,
  output logic [31:0] prog_addr,
  output logic [7:0] prog_data,
  input wire logic prog_done,
  input wire logic prog_ok,
  output logic jump_req,
  output logic [31:0] jump_addr,
  output logic restart_req,
  output logic [7:0] status_code
);
  slpe_state_t state_r;
  logic [7:0] packet_length_byte_r;
  logic [7:0] payload_sum_byte_r;
  logic [7:0] calc_sum_r;
  logic [7:0] idx_r;
  logic [3:0] cnt_r;
  logic [7:0] pay_r [11];
  logic [31:0] cur_addr_r;
  logic [31:0] remain_r;
  logic [7:0] status_r;
  logic good_r;
  logic [7:0] sum_nxt;
  logic rx_take;
  logic [7:0] tx_byte;
  logic tx_load;
  logic tx_in_ready;
  logic [7:0] cmd;
  logic [31:0] param_a;
  logic [31:0] param_b;

  // link framing settings are fixed for the synchronous port
  assign clock_polarity_select = 1'b1; // RULE_25
  assign clock_phase_select = 1'b1; // RULE_25

  assign cmd = pay_r[0];
  assign param_a = {pay_r[1], pay_r[2], pay_r[3], pay_r[4]}; // RULE_14
  assign param_b = {pay_r[5], pay_r[6], pay_r[7], pay_r[8]}; // RULE_14
  assign sum_nxt = calc_sum_r + rx_data; // RULE_26
  assign status_code = status_r;
  assign erase_addr = cur_addr_r;
  assign erase_size = remain_r;

  always_comb begin
    rx_ready = 1'b0;
    case (state_r)
      SLPE_SYNC1, SLPE_SYNC2, SLPE_IDLE, SLPE_SUM, SLPE_PAY, SLPE_RESP: rx_ready = 1'b1;
      default: rx_ready = 1'b0;
    endcase
  end
  assign rx_take = rx_valid && rx_ready;

  // outgoing bytes pass a two-entry buffer so a stalled receiver loses nothing
  always_comb begin
    tx_load = 1'b0;
    tx_byte = 8'h00;
    case (state_r)
      SLPE_ACKTX: begin
        tx_load = 1'b1;
        tx_byte = good_r ? `SLPE_ACK : `SLPE_NAK; // RULE_04 RULE_05
      end
      SLPE_TXLEN: begin
        tx_load = 1'b1;
        tx_byte = `SLPE_LEN_REPLY; // RULE_01 RULE_07
      end
      SLPE_TXSUM, SLPE_TXDAT: begin
        tx_load = 1'b1;
        tx_byte = status_r; // RULE_02 RULE_13
      end
      default: begin
        tx_load = 1'b0;
        tx_byte = 8'h00;
      end
    endcase
  end

  slpe_skid u_txbuf (
    .clock(clock),
    .rst_n(rst_n),
    .in_data(tx_byte),
    .in_valid(tx_load),
    .in_ready(tx_in_ready),
    .out_data(tx_data),
    .out_valid(tx_valid),
    .out_ready(tx_ready)
  );

  // packet reception
  always_ff @(posedge clock) begin
    if (rx_take && state_r == SLPE_PAY && idx_r < {4'h0, `SLPE_PAYLOAD_MAX}) begin
      pay_r[idx_r[3:0]] <= rx_data;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      packet_length_byte_r <= 8'h00;
      payload_sum_byte_r <= 8'h00;
      calc_sum_r <= 8'h00;
      idx_r <= 8'h00;
    end else if (rx_take) begin
      case (state_r)
        SLPE_IDLE: begin
          packet_length_byte_r <= rx_data; // RULE_01
          calc_sum_r <= 8'h00;
          idx_r <= 8'h00;
        end
        SLPE_SUM: payload_sum_byte_r <= rx_data; // RULE_02
        SLPE_PAY: begin
          calc_sum_r <= sum_nxt; // RULE_02 RULE_26
          idx_r <= idx_r + 8'h01;
        end
        default: idx_r <= idx_r;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_r <= SLPE_SYNC1;
      good_r <= 1'b0;
      cnt_r <= 4'h0;
    end else begin
      case (state_r)
        SLPE_SYNC1: begin
          if (!link_is_async) begin
            state_r <= SLPE_IDLE;
          end else if (rx_take && rx_data == `SLPE_SYNC) begin
            state_r <= SLPE_SYNC2; // RULE_24
          end
        end
        SLPE_SYNC2: begin
          if (rx_take) begin
            if (rx_data == `SLPE_SYNC) begin
              good_r <= 1'b1;
              state_r <= SLPE_ACKTX; // RULE_24
            end else begin
              state_r <= SLPE_SYNC1;
            end
          end
        end
        SLPE_IDLE: begin
          // leading zero bytes are fill, not a length
          if (rx_take && rx_data != 8'h00) begin
            state_r <= SLPE_SUM;
          end
        end
        SLPE_SUM: begin
          if (rx_take) begin
            state_r <= SLPE_PAY;
          end
        end
        SLPE_PAY: begin
          if (rx_take && idx_r + `SLPE_LEN_MIN >= packet_length_byte_r) begin // RULE_03
            state_r <= SLPE_EXEC;
          end
        end
        SLPE_EXEC: begin
          good_r <= 1'b1;
          // lengths beyond the store cannot be held, so they are refused
          if (packet_length_byte_r < `SLPE_LEN_MIN
              || packet_length_byte_r > {4'h0, `SLPE_PAYLOAD_MAX} + 8'h02
              || calc_sum_r != payload_sum_byte_r) begin
            good_r <= 1'b0; // RULE_26 RULE_04
            state_r <= SLPE_ACKTX;
          end else if (cmd == `SLPE_CMD_SETUP && packet_length_byte_r == `SLPE_LEN_SETUP
                       && addr_ok) begin
            state_r <= SLPE_WAITERASE; // RULE_15
          end else if (cmd == `SLPE_CMD_WRITE && remain_r != 32'h0) begin
            cnt_r <= 4'h0;
            state_r <= SLPE_PROG; // RULE_16
          end else begin
            state_r <= SLPE_ACKTX;
          end
        end
        SLPE_WAITERASE: begin
          if (erase_done) begin
            state_r <= SLPE_ACKTX; // RULE_15
          end
        end
        SLPE_PROG: begin
          if ({4'h0, cnt_r} + 8'h03 >= packet_length_byte_r || remain_r == 32'h0) begin
            state_r <= SLPE_ACKTX; // RULE_18
          end else begin
            state_r <= SLPE_WAITPROG;
          end
        end
        SLPE_WAITPROG: begin
          if (prog_done) begin
            cnt_r <= cnt_r + 4'h1;
            state_r <= SLPE_PROG;
          end
        end
        SLPE_ACKTX: begin
          if (tx_in_ready) begin
            // a sync ack leaves the length cleared, so a stale query never replies
            if (!good_r) begin
              state_r <= SLPE_IDLE;
            end else if (cmd == `SLPE_CMD_QUERY && packet_length_byte_r == `SLPE_LEN_SHORT) begin
              state_r <= SLPE_TXLEN; // RULE_13
            end else if (cmd == `SLPE_CMD_JUMP && packet_length_byte_r == `SLPE_LEN_JUMP) begin
              state_r <= SLPE_FINAL; // RULE_22
            end else if (cmd == `SLPE_CMD_RESTART && packet_length_byte_r == `SLPE_LEN_SHORT)
            begin
              state_r <= SLPE_FINAL; // RULE_23
            end else begin
              state_r <= SLPE_IDLE;
            end
          end
        end
        SLPE_TXLEN: begin
          if (tx_in_ready) begin
            state_r <= SLPE_TXSUM; // RULE_08
          end
        end
        SLPE_TXSUM: begin
          if (tx_in_ready) begin
            state_r <= SLPE_TXDAT; // RULE_08
          end
        end
        SLPE_TXDAT: begin
          if (tx_in_ready) begin
            state_r <= SLPE_RESP;
          end
        end
        SLPE_RESP: begin
          if (rx_take && rx_data != 8'h00) begin
            state_r <= SLPE_IDLE; // RULE_09
          end
        end
        SLPE_FINAL: begin
          // hold here until the acknowledge has drained out of the buffer
          if (!tx_valid) begin
            state_r <= SLPE_IDLE;
          end
        end
        default: state_r <= SLPE_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      status_r <= `SLPE_ST_SUCCESS;
    end else if (state_r == SLPE_EXEC && good_r_ok(packet_length_byte_r, calc_sum_r,
                                                 payload_sum_byte_r)) begin
      if (cmd == `SLPE_CMD_PROBE && packet_length_byte_r == `SLPE_LEN_SHORT) begin
        status_r <= `SLPE_ST_SUCCESS; // RULE_12
      end else if (cmd == `SLPE_CMD_SETUP && packet_length_byte_r == `SLPE_LEN_SETUP) begin
        status_r <= addr_ok ? `SLPE_ST_SUCCESS : `SLPE_ST_BADADDR; // RULE_27
      end else if (cmd == `SLPE_CMD_WRITE) begin
        status_r <= remain_r != 32'h0 ? `SLPE_ST_SUCCESS : `SLPE_ST_BADADDR; // RULE_18
      end else if (cmd == `SLPE_CMD_QUERY && packet_length_byte_r == `SLPE_LEN_SHORT) begin
        status_r <= status_r; // RULE_13
      end else if ((cmd == `SLPE_CMD_JUMP && packet_length_byte_r == `SLPE_LEN_JUMP)
                   || (cmd == `SLPE_CMD_RESTART && packet_length_byte_r == `SLPE_LEN_SHORT))
      begin
        status_r <= `SLPE_ST_SUCCESS;
      end else begin
        status_r <= `SLPE_ST_UNKNOWN; // RULE_11 RULE_27
      end
    end else if (state_r == SLPE_WAITERASE && erase_done && !erase_ok) begin
      status_r <= `SLPE_ST_PROGFAIL; // RULE_27
    end else if (state_r == SLPE_WAITPROG && prog_done && !prog_ok) begin
      status_r <= `SLPE_ST_PROGFAIL; // RULE_27
    end
  end

  function automatic logic good_r_ok(input logic [7:0] len, input logic [7:0] a,
                                     input logic [7:0] b);
    good_r_ok = len >= `SLPE_LEN_MIN && len <= {4'h0, `SLPE_PAYLOAD_MAX} + 8'h02 && a == b;
  endfunction

  // program address and remaining count
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cur_addr_r <= 32'h0;
      remain_r <= 32'h0;
    end else if (state_r == SLPE_EXEC && cmd == `SLPE_CMD_SETUP && addr_ok
                 && packet_length_byte_r == `SLPE_LEN_SETUP
                 && good_r_ok(packet_length_byte_r, calc_sum_r, payload_sum_byte_r)) begin
      cur_addr_r <= param_a; // RULE_14
      remain_r <= param_b; // RULE_14
    end else if (state_r == SLPE_WAITPROG && prog_done) begin
      // only intact packets reach programming, so a refused write never moves it
      cur_addr_r <= cur_addr_r + 32'h1; // RULE_16 RULE_19
      remain_r <= remain_r - 32'h1; // RULE_18
    end
  end

  // flash, jump and restart requests
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      erase_req <= 1'b0;
      prog_req <= 1'b0;
      prog_addr <= 32'h0;
      prog_data <= 8'h00;
      jump_req <= 1'b0;
      jump_addr <= 32'h0;
      restart_req <= 1'b0;
    end else begin
      erase_req <= state_r == SLPE_EXEC && cmd == `SLPE_CMD_SETUP && addr_ok
                   && packet_length_byte_r == `SLPE_LEN_SETUP
                   && good_r_ok(packet_length_byte_r, calc_sum_r, payload_sum_byte_r);
      prog_req <= state_r == SLPE_PROG && {4'h0, cnt_r} + 8'h03 < packet_length_byte_r
                  && remain_r != 32'h0;
      if (state_r == SLPE_PROG) begin
        prog_addr <= cur_addr_r; // RULE_16
        prog_data <= pay_r[cnt_r + 4'h1];
      end
      jump_req <= state_r == SLPE_FINAL && !tx_valid && cmd == `SLPE_CMD_JUMP; // RULE_22
      if (state_r == SLPE_EXEC) begin
        jump_addr <= param_a; // RULE_22
      end
      restart_req <= state_r == SLPE_FINAL && !tx_valid && cmd == `SLPE_CMD_RESTART; // RULE_23
    end
  end
endmodule // slpe_engine

// [src/slpe_regs.svh]
`ifndef SLPE_REGS_SVH
`define SLPE_REGS_SVH
`define SLPE_ACK 8'hCC
`define SLPE_NAK 8'h33
`define SLPE_SYNC 8'h55
`define SLPE_CMD_PROBE 8'h20
`define SLPE_CMD_SETUP 8'h21
`define SLPE_CMD_JUMP 8'h22
`define SLPE_CMD_QUERY 8'h23
`define SLPE_CMD_WRITE 8'h24
`define SLPE_CMD_RESTART 8'h25
`define SLPE_LEN_SHORT 8'h03
`define SLPE_LEN_JUMP 8'h07
`define SLPE_LEN_SETUP 8'h0B
`define SLPE_LEN_REPLY 8'h03
`define SLPE_LEN_MIN 8'h03
`define SLPE_PAYLOAD_MAX 4'hB
`define SLPE_ST_SUCCESS 8'h40
`define SLPE_ST_UNKNOWN 8'h41
`define SLPE_ST_BADADDR 8'h42
`define SLPE_ST_PROGFAIL 8'h43
`endif

// [src/slpe_pkg.sv]
package slpe_pkg;
  typedef enum logic [3:0] {
    SLPE_SYNC1, SLPE_SYNC2, SLPE_IDLE, SLPE_SUM, SLPE_PAY, SLPE_EXEC, SLPE_WAITERASE,
    SLPE_PROG, SLPE_WAITPROG, SLPE_ACKTX, SLPE_TXLEN, SLPE_TXSUM, SLPE_TXDAT, SLPE_RESP,
    SLPE_FINAL
  } slpe_state_t;
endpackage

// [src/slpe_skid.sv]
module slpe_skid (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [7:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  logic [7:0] mem_r [2];
  logic rd_r, wr_r;
  logic [1:0] cnt_r;
  logic push, pop;
  assign in_ready = cnt_r != 2'h2;
  assign out_valid = cnt_r != 2'h0;
  assign out_data = mem_r[rd_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_ff @(posedge clock) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rd_r <= 1'b0;
      wr_r <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      if (push) begin
        wr_r <= ~wr_r;
      end
      if (pop) begin
        rd_r <= ~rd_r;
      end
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // slpe_skid

// [sim/slpe_engine_assertions.sv]
module slpe_chk (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic rx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic clock_polarity_select,
  input wire logic clock_phase_select,
  input wire logic erase_req,
  input wire logic prog_req,
  input wire logic [31:0] prog_addr,
  input wire logic jump_req,
  input wire logic restart_req,
  input wire logic [7:0] status_code
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic seen_r;
  logic [31:0] last_r;
  // a fresh setup restarts the address chain
  always_ff @(posedge clock) begin
    if (!rst_n || erase_req) begin
      seen_r <= 1'b0;
    end else if (prog_req) begin
      seen_r <= 1'b1;
    end
  end
  always_ff @(posedge clock) begin
    if (prog_req) begin
      last_r <= prog_addr;
    end
  end
  reset_state_a: assert property (disable iff (1'b0) !rst_n |=> status_code == 8'h40 && !tx_valid)
    else $error("state after reset wrong");
  erase_wait_a: assert property (erase_req |=> (!tx_valid && !rx_ready) [*8])
    else $error("answer before erase finished");
  tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("outgoing byte dropped or changed");
  link_mode_a: assert property (clock_polarity_select && clock_phase_select)
    else $error("link clock mode wrong");
  addr_step_a: assert property (prog_req && seen_r |-> prog_addr == last_r + 32'h1)
    else $error("program address did not advance by one");
  prog_pulse_a: assert property (prog_req |=> !prog_req)
    else $error("program request longer than a cycle");
  jump_after_a: assert property (jump_req |-> !tx_valid)
    else $error("jump before answer drained");
  jump_pulse_a: assert property (jump_req |=> !jump_req && !restart_req)
    else $error("jump request malformed");
  restart_after_a: assert property (restart_req |-> !tx_valid)
    else $error("restart before answer drained");
  cover property (erase_req);
  cover property (jump_req);
  cover property (restart_req);
  cover property (tx_valid && !tx_ready);
endmodule // slpe_chk

bind slpe_engine slpe_chk u_chk (.clock, .rst_n, .rx_ready, .tx_data, .tx_valid, .tx_ready,
  .clock_polarity_select, .clock_phase_select, .erase_req, .prog_req, .prog_addr, .jump_req,
  .restart_req, .status_code);

// [sim/slpe_host.sv]
module slpe_host (
  input wire logic clock,
  input wire logic rx_ready,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] cyc_r = 2'h0;
  initial begin
    rx_data = 8'hFF;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
  end
  // stall one cycle in four so the device buffer must hold bytes
  always @(posedge clock) begin
    #1;
    cyc_r = cyc_r + 2'h1;
    tx_ready = (cyc_r != 2'h3);
  end
  task automatic send_raw(input logic [7:0] p[$]);
    @(posedge clock) #1;
    foreach (p[i]) begin
      rx_data = p[i];
      rx_valid = 1'b1;
      do @(posedge clock); while (!rx_ready);
      #1;
    end
    rx_valid = 1'b0;
    rx_data = ~rx_data; // a released line must not repeat the last byte
  endtask
  // leading zero is padding the device has to skip
  task automatic send_pkt(input logic [7:0] p[$], input logic bad);
    logic [7:0] s;
    s = 8'h00;
    foreach (p[i]) s += p[i];
    if (bad) s = ~s;
    send_raw({8'h00, 8'(p.size() + 2), s, p});
  endtask
  task automatic get_byte(output logic [7:0] b);
    do @(posedge clock); while (!(tx_valid && tx_ready));
    b = tx_data;
  endtask
  task automatic recv_nz(output logic [7:0] b);
    do get_byte(b); while (b == 8'h00);
  endtask
endmodule // slpe_host

// [sim/testbench.sv]
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic erase_done = 1'b0;
  logic prog_done = 1'b0;
  logic addr_ok = 1'b1;
  logic erase_ok = 1'b1;
  logic link_async = 1'b1;
  logic [7:0] rx_data, tx_data, prog_data, status_code, b;
  logic rx_valid, rx_ready, tx_valid, tx_ready, erase_req, prog_req, jump_req, restart_req;
  logic [31:0] erase_addr, erase_size, prog_addr, jump_addr, got_j;
  logic [4:0] ecnt_r = 5'h00;
  logic [31:0] pa[$];
  logic [7:0] pd[$];
  int n_mismatch = 0;
  int comparisons = 0;
  int n_erase = 0;
  int n_jump = 0;
  int n_rst = 0;
  always #2.5 clock = ~clock;
  // flash stand-in: erase is slow so an early answer shows
  always @(posedge clock) begin
    prog_done <= prog_req;
    erase_done <= (ecnt_r == 5'h01);
    ecnt_r <= erase_req ? 5'h14 : (ecnt_r != 5'h00 ? ecnt_r - 5'h01 : 5'h00);
    if (prog_req) begin
      pa.push_back(prog_addr);
      pd.push_back(prog_data);
    end
    if (erase_req) n_erase++;
    if (jump_req) got_j = jump_addr;
    if (jump_req) n_jump++;
    if (restart_req) n_rst++;
  end
  slpe_engine dut (.clock, .rst_n, .link_is_async(link_async), .rx_data, .rx_valid, .rx_ready,
    .tx_data, .tx_valid, .tx_ready, .clock_polarity_select(), .clock_phase_select(),
    .erase_req, .erase_addr, .erase_size, .erase_done, .erase_ok, .addr_ok,
    .prog_req, .prog_addr, .prog_data, .prog_done, .prog_ok(1'b1), .jump_req, .jump_addr,
    .restart_req, .status_code);
  slpe_host host (.clock, .rx_ready, .rx_data, .rx_valid, .tx_data, .tx_valid, .tx_ready);
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test;
    if (n_mismatch == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic answer(input logic [7:0] exp);
    host.recv_nz(b);
    chk8("answer", exp, b);
  endtask
  task automatic do_reset(input logic async_link);
    #1 rst_n = 1'b0;
    link_async = async_link;
    repeat (4) @(posedge clock);
    #1 rst_n = 1'b1;
  endtask
  task automatic t_sync;
    host.send_raw('{8'h55, 8'h55});
    answer(8'hCC);
  endtask
  task automatic t_ping;
    host.send_pkt('{8'h20}, 1'b0);
    answer(8'hCC);
    chk8("status", 8'h40, status_code);
  endtask
  task automatic t_bad;
    host.send_pkt('{8'h21}, 1'b1);
    answer(8'h33);
    host.send_pkt('{8'h30}, 1'b0);
    answer(8'hCC);
    chk8("status", 8'h41, status_code);
  endtask
  task automatic query(input logic [7:0] exp, input logic [7:0] reply);
    host.send_pkt('{8'h23}, 1'b0);
    answer(8'hCC);
    host.recv_nz(b);
    chk8("reply length", 8'h03, b);
    host.get_byte(b);
    chk8("reply sum", exp, b);
    host.get_byte(b);
    chk8("reply status", exp, b);
    host.send_raw('{8'h00, reply});
  endtask
  task automatic t_query;
    query(8'h41, 8'h33);
    query(8'h41, 8'hCC);
    t_ping();
  endtask
  task automatic t_setup;
    host.send_pkt('{8'h21, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0A}, 1'b0);
    answer(8'hCC);
    chk32("erase_addr", 32'h00001000, erase_addr);
    chk32("erase_size", 32'h0000000A, erase_size);
    chk32("erases", 32'h00000001, n_erase);
  endtask
  task automatic wr(input logic [7:0] base, input logic bad, input logic [7:0] exp);
    logic [7:0] p[$];
    p = '{8'h24};
    for (int i = 0; i < 8; i++) p.push_back(base + 8'(i));
    host.send_pkt(p, bad);
    answer(exp);
  endtask
  task automatic t_write;
    wr(8'hA0, 1'b0, 8'hCC);
    wr(8'hB0, 1'b1, 8'h33);
    wr(8'hC0, 1'b0, 8'hCC);
    wr(8'hD0, 1'b0, 8'hCC);
    query(8'h42, 8'hCC);
    chk32("programmed", 32'h0000000A, pa.size());
    for (int i = 0; i < 10; i++) begin
      chk32("prog_addr", 32'h00001000 + 32'(i), pa[i]);
      chk8("prog_data", (i < 8 ? 8'hA0 : 8'hB8) + 8'(i), pd[i]);
    end
  endtask
  task automatic t_fail;
    @(posedge clock) #1 addr_ok = 1'b0;
    host.send_pkt('{8'h21, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04}, 1'b0);
    answer(8'hCC);
    query(8'h42, 8'hCC);
    @(posedge clock) #1 addr_ok = 1'b1;
    erase_ok = 1'b0;
    host.send_pkt('{8'h21, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04}, 1'b0);
    answer(8'hCC);
    query(8'h43, 8'hCC);
    chk32("erases", 32'h00000002, n_erase);
    @(posedge clock) #1 erase_ok = 1'b1;
  endtask
  task automatic t_restart;
    host.send_pkt('{8'h25}, 1'b0);
    answer(8'hCC);
    for (int i = 0; i < 50 && n_rst == 0; i++) @(posedge clock);
    chk32("restarts", 32'h00000001, n_rst);
  endtask
  task automatic t_jump;
    host.send_pkt('{8'h22, 8'h12, 8'h34, 8'h56, 8'h78}, 1'b0);
    answer(8'hCC);
    for (int i = 0; i < 50 && n_jump == 0; i++) @(posedge clock);
    chk32("jumps", 32'h00000001, n_jump);
    chk32("jump_addr", 32'h12345678, got_j);
  endtask
  initial begin
    #100us;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    do_reset(1'b1);
    t_sync();
    t_ping();
    t_bad();
    t_query();
    t_setup();
    t_write();
    t_fail();
    t_restart();
    do_reset(1'b1);
    t_sync();
    t_jump();
    do_reset(1'b0);
    t_ping();
    end_of_test();
  end
endmodule // testbench
